//--- common/msi_pkg.sv
// Purpose: shared constants and carriers for the media status / identify engine
// Assumes: 40 MHz core clock, task-file registers addressed by a 3-bit offset
// Notes:   one name per number; modules import the whole package
package msi_pkg;
  // timing
  localparam int CLK_NS   = 25;
  localparam int PREP_NS  = 500;
  localparam int PREP_CYC = (PREP_NS + CLK_NS - 1) / CLK_NS;

  // task-file register offsets
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_ERR  = 3'h1;
  localparam logic [2:0] A_SCNT = 3'h2;
  localparam logic [2:0] A_CYLH = 3'h5;
  localparam logic [2:0] A_DEVH = 3'h6;
  localparam logic [2:0] A_STAT = 3'h7;

  // command codes
  localparam logic [7:0] CMD_GMS   = 8'hda;
  localparam logic [7:0] CMD_IDENT = 8'hec;

  // error_flags field positions
  localparam int EB_WP   = 6;
  localparam int EB_MC   = 5;
  localparam int EB_MCR  = 3;
  localparam int EB_ABRT = 2;
  localparam int EB_NM   = 1;

  // command_state field positions and device_select bit
  localparam int SB_BSY  = 7;
  localparam int SB_DRDY = 6;
  localparam int SB_DF   = 5;
  localparam int SB_DRQ  = 3;
  localparam int SB_ERR  = 0;
  localparam int DH_DEV  = 4;

  // reset values
  localparam logic [7:0] ERR_RST  = 8'h00;
  localparam logic [7:0] DEVH_RST = 8'h00;

  // identification layout
  localparam logic [7:0] ID_LAST  = 8'hff;
  localparam logic [7:0] ASCII_LO = 8'h20;
  localparam logic [7:0] ASCII_HI = 8'h7e;
  localparam int W_CONFIG = 0;
  localparam int W_CYL    = 1;
  localparam int W_HEAD   = 3;
  localparam int W_SECT   = 6;
  localparam int W_SER    = 10;
  localparam int N_SER    = 10;
  localparam int W_FW     = 23;
  localparam int N_FW     = 4;
  localparam int W_MODEL  = 27;
  localparam int N_MODEL  = 20;
  localparam int W_MULT   = 47;
  localparam int W_CAP    = 49;
  localparam int W_CAP2   = 50;
  localparam int W_TOTAL  = 60;
  localparam int CFG_RMV  = 7;

  // synchronised pin vector layout
  localparam int P_MEDIA = 0;
  localparam int P_WP    = 1;
  localparam int P_EJECT = 2;
  localparam int P_NIEN  = 3;
  localparam int P_MSN   = 4;
  localparam int P_FAULT = 5;
  localparam int NPIN    = 6;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } msi_req_s;

  typedef struct packed {
    logic media;
    logic wp;
    logic nien;
    logic msn;
    logic fault;
    logic mc;
    logic mcr;
  } msi_media_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_PREP = 4'b0100,
    ST_XFER = 4'b1000
  } msi_state_e;
endpackage

//--- rtl/msi_ident_rom.sv
// Purpose: identification word generator, indexed by word number
// Assumes: caller registers the result
// Notes:   every word not listed reads zero
`timescale 1ns/1ps
module msi_ident_rom #(
  parameter logic [15:0]  CYLS   = 16'h0400,
  parameter logic [15:0]  HEADS  = 16'h0010,
  parameter logic [15:0]  SECTS  = 16'h003f,
  parameter logic [31:0]  TOTAL  = 32'h000fc000,
  parameter logic [159:0] SERIAL = "SN0000000000000000 1",
  parameter logic [63:0]  FWREV  = "REV 1.00",
  parameter logic [319:0] MODEL  = "GENERIC REMOVABLE DRIVE"
) (
  // word select and data
  input  wire logic [7:0]  idx,
  output logic      [15:0] word
);
  import msi_pkg::*;

  // out-of-range codes become spaces so the string stays graphic
  function automatic logic [7:0] gfx(input logic [7:0] c);
    gfx = (c < ASCII_LO || c > ASCII_HI) ? ASCII_LO : c; // see R15
  endfunction

  // earlier character on the high byte, strings walk forward by word
  function automatic logic [15:0] pair(input logic [319:0] s, input int nch, input int k);
    pair = {gfx(s[8*(nch-1-2*k) +: 8]), gfx(s[8*(nch-2-2*k) +: 8])}; // see R16
  endfunction

  int w;
  always_comb begin
    w = int'(idx);
    word = 16'h0000; // see R12
    if (w == W_CONFIG)                         word[CFG_RMV] = 1'b1;
    else if (w == W_CYL)                       word = CYLS; // see R13
    else if (w == W_HEAD)                      word = HEADS;
    else if (w == W_SECT)                      word = SECTS;
    else if (w >= W_SER && w < W_SER + N_SER)  word = pair(320'(SERIAL), 20, w - W_SER);
    else if (w >= W_FW && w < W_FW + N_FW)     word = pair(320'(FWREV), 8, w - W_FW);
    else if (w >= W_MODEL && w < W_MODEL + N_MODEL) word = pair(MODEL, 40, w - W_MODEL);
    else if (w == W_MULT)                      word = 16'h8000;
    else if (w == W_CAP)                       word = 16'h0300;
    else if (w == W_CAP2)                      word = 16'h4000;
    else if (w == W_TOTAL)                     word = TOTAL[15:0]; // see R14
    else if (w == W_TOTAL + 1)                 word = TOTAL[31:16]; // see R14
  end
endmodule

//--- rtl/msi_media_track.sv
// Purpose: pin synchroniser and sticky media event flags
// Assumes: pins are asynchronous to clk
// Notes:   a set in the clearing cycle survives the clear
`timescale 1ns/1ps
module msi_media_track (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // raw pins, layout per P_* constants
  input  wire logic [5:0]      pins,
  // clear of the sticky flags after a status command
  input  wire logic            clr,
  // synchronised view
  output msi_pkg::msi_media_s  med
);
  import msi_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] lvl;
    logic            mc;
    logic            mcr;
  } msi_trk_s;

  msi_trk_s s_ff, nxt_s;
  logic     ins, press;

  // a level only moves once stages two and three agree
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.s1  = pins;
    nxt_s.s2  = s_ff.s1;
    nxt_s.s3  = s_ff.s2;
    nxt_s.lvl = (s_ff.s2 & s_ff.s3) | (s_ff.lvl & (s_ff.s2 ^ s_ff.s3));
    ins       = nxt_s.lvl[P_MEDIA] & ~s_ff.lvl[P_MEDIA];
    press     = nxt_s.lvl[P_EJECT] & ~s_ff.lvl[P_EJECT];
    nxt_s.mc  = (s_ff.mc & ~clr) | ins; // see R5
    nxt_s.mcr = (s_ff.mcr & ~clr) | press; // see R4
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign med = '{media: s_ff.lvl[P_MEDIA], wp: s_ff.lvl[P_WP], nien: s_ff.lvl[P_NIEN],
                 msn: s_ff.lvl[P_MSN], fault: s_ff.lvl[P_FAULT], mc: s_ff.mc, mcr: s_ff.mcr};

  property p_mcr_clear;
    @(posedge clk) disable iff (!rst_n) (clr && !press) |=> !s_ff.mcr;
  endproperty
  a_mcr_clear: assert property (p_mcr_clear) else $error("eject flag survived clear"); // see R4

  property p_mc_set;
    @(posedge clk) disable iff (!rst_n) ins |=> s_ff.mc;
  endproperty
  a_mc_set: assert property (p_mc_set) else $error("insertion not latched"); // see R5
endmodule

//--- rtl/msi_cmd_top.sv
// Purpose: device-side engine for the media status and identify commands
// Assumes: host strobes rd/wr for one cycle each; reads answer one cycle later
// Notes:   nien, notification enable and fault arrive as pins
//
// Function
// R1: notification off or clean: plain good completion
// R2: error bits WP6 MC5 MCR3 ABRT2 NM1
// R3: NM reported each time while media absent
// R4: eject press latched, cleared per status command
// R5: insertion latched, cleared per status command
// R6: WP reported each time media protected
// R7: error completion: ERR tracks any error bit
// R8: notification off returns zero media bits
// R9: identify ECh is PIO data-in command
// R10: identify: busy, prepare, DRQ, optional interrupt
// R11: host reads words from data register
// R12: reserved identification bits read zero
// R13: word msb on DD15, lsb on DD0
// R14: 32-bit values low word first
// R15: strings hold only graphic codes
// R16: earlier character in high byte
// R17: packet device aborts identify, loads signature
// R18: non-packet device never errors identify
`timescale 1ns/1ps
module msi_cmd_top #(
  parameter bit          PACKET  = 1'b0,
  parameter bit          DEV_NUM = 1'b0,
  parameter int          PREP    = msi_pkg::PREP_CYC,
  parameter logic [31:0] SIG     = 32'h0000_0000  // arbitrary signature value
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // task-file access
  input  msi_pkg::msi_req_s     req,
  output logic      [15:0]      rdata,
  output logic                  intrq,
  // device pins
  input  wire logic [5:0]       pins
);
  import msi_pkg::*;

  if (PREP < 1 || PREP > 255) begin : g_chk
    $error("PREP must be 1..255 cycles");
  end

  typedef struct packed {
    msi_state_e       st;
    logic [7:0]       err;
    logic             errst;
    logic             df;
    logic [7:0]       cnt;
    logic [7:0]       idx;
    logic [7:0]       devh;
    logic [3:0][7:0]  cblk;
    logic             intrq;
    logic [15:0]      rdata;
  } msi_top_s;

  msi_top_s   s_ff, nxt_s;
  msi_media_s med;
  logic [15:0] id_word;
  logic [7:0]  stat, merr;
  logic        cmd_take, bsy;

  msi_media_track u_trk (
    .clk   (clk),
    .rst_n (rst_n),
    .pins  (pins),
    .clr   (s_ff.st == ST_EXEC),
    .med   (med)
  );

  msi_ident_rom u_rom (
    .idx  (s_ff.idx),
    .word (id_word)
  );

  // status byte and media error view
  always_comb begin
    bsy            = (s_ff.st == ST_EXEC) || (s_ff.st == ST_PREP);
    stat           = 8'h00;
    stat[SB_BSY]   = bsy;
    stat[SB_DRDY]  = !bsy;
    stat[SB_DF]    = s_ff.df;
    stat[SB_DRQ]   = (s_ff.st == ST_XFER);
    stat[SB_ERR]   = s_ff.errst;
    merr           = 8'h00;
    merr[EB_WP]    = med.msn & med.media & med.wp; // see R6
    merr[EB_MC]    = med.msn & med.mc; // see R5
    merr[EB_MCR]   = med.msn & med.mcr; // see R4
    merr[EB_NM]    = med.msn & ~med.media; // see R3, R8
    cmd_take       = req.wr && req.addr == A_STAT && s_ff.st == ST_IDLE
                     && s_ff.devh[DH_DEV] == DEV_NUM;
  end

  // command sequencing and register access
  always_comb begin
    nxt_s = s_ff;
    if (req.wr && s_ff.st == ST_IDLE) begin
      if (req.addr == A_DEVH) nxt_s.devh = req.wdata;
      if (req.addr >= A_SCNT && req.addr <= A_CYLH) begin
        nxt_s.cblk[req.addr - A_SCNT] = req.wdata;
      end
    end
    case (s_ff.st)
      ST_IDLE: begin
        if (cmd_take) begin
          nxt_s.intrq = 1'b0;
          nxt_s.df    = 1'b0;
          nxt_s.err   = ERR_RST;
          nxt_s.errst = 1'b0;
          if (req.wdata == CMD_GMS) begin
            nxt_s.st = ST_EXEC;
          end else if (req.wdata == CMD_IDENT && !PACKET) begin
            nxt_s.st  = ST_PREP; // see R9, R10, R18
            nxt_s.cnt = 8'(PREP - 1);
          end else begin
            // unsupported command, or identify on a packet device
            nxt_s.err[EB_ABRT] = 1'b1; // see R2, R17
            nxt_s.errst        = 1'b1; // see R7
            nxt_s.intrq        = !med.nien;
            if (req.wdata == CMD_IDENT) begin
              nxt_s.cblk = SIG; // see R17
            end
          end
        end
      end
      ST_EXEC: begin
        // flags are captured in the same edge the tracker clears them
        nxt_s.err   = merr; // see R2, R3, R6, R8
        nxt_s.errst = |merr; // see R1, R7
        nxt_s.df    = med.fault & (|merr); // see R1, R7: a clean finish never shows a fault
        nxt_s.intrq = !med.nien;
        nxt_s.st    = ST_IDLE;
      end
      ST_PREP: begin
        if (s_ff.cnt == 8'h00) begin
          nxt_s.st    = ST_XFER; // see R10
          nxt_s.idx   = 8'h00;
          nxt_s.intrq = !med.nien; // see R10
        end else begin
          nxt_s.cnt = s_ff.cnt - 8'h01;
        end
      end
      ST_XFER: begin
        nxt_s.st = ST_XFER;
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
    if (req.rd) begin
      case (req.addr)
        A_DATA: begin
          nxt_s.rdata = 16'h0000;
          if (s_ff.st == ST_XFER) begin
            nxt_s.rdata = id_word; // see R11, R13
            nxt_s.idx   = s_ff.idx + 8'h01;
            if (s_ff.idx == ID_LAST) nxt_s.st = ST_IDLE; // see R9
          end
        end
        A_ERR:   nxt_s.rdata = {8'h00, s_ff.err};
        A_DEVH:  nxt_s.rdata = {8'h00, s_ff.devh};
        A_STAT: begin
          nxt_s.rdata = {8'h00, stat};
          // acknowledge only an interrupt already standing; one raised on this
          // edge survives, since the host has just read the busy status
          nxt_s.intrq = nxt_s.intrq & ~s_ff.intrq;
        end
        default: nxt_s.rdata = {8'h00, s_ff.cblk[req.addr - A_SCNT]};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff       <= '0;
      s_ff.st    <= ST_IDLE;
      s_ff.err   <= ERR_RST;
      s_ff.devh  <= DEVH_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rdata;
  assign intrq = s_ff.intrq;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ident_busy;
    (cmd_take && req.wdata == CMD_IDENT && !PACKET) |=> s_ff.st == ST_PREP && bsy;
  endproperty
  a_ident_busy: assert property (p_ident_busy) else $error("identify not busy"); // see R10

  property p_drq_irq;
    $rose(s_ff.st == ST_XFER) |-> !bsy && s_ff.idx == 8'h00
                                 && s_ff.intrq == !$past(med.nien);
  endproperty
  a_drq_irq: assert property (p_drq_irq) else $error("drq entry wrong"); // see R10

  property p_gms_nm;
    (s_ff.st == ST_EXEC && med.msn && !med.media) |=> s_ff.err[EB_NM] && s_ff.errst;
  endproperty
  a_gms_nm: assert property (p_gms_nm) else $error("no media not reported"); // see R3

  property p_gms_off;
    (s_ff.st == ST_EXEC && !med.msn) |=> s_ff.err == 8'h00 && !s_ff.errst && !bsy;
  endproperty
  a_gms_off: assert property (p_gms_off) else $error("media bits with notify off"); // see R8

  property p_err_sum;
    (s_ff.st == ST_IDLE) |-> s_ff.errst == (s_ff.err != 8'h00);
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("err status mismatch"); // see R7

  property p_abort;
    (cmd_take && req.wdata != CMD_GMS && req.wdata != CMD_IDENT)
      |=> s_ff.err[EB_ABRT] && s_ff.errst && s_ff.st == ST_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not posted"); // see R2

  property p_reserved;
    (req.rd && req.addr == A_DATA && s_ff.st == ST_XFER && s_ff.idx == 8'h02)
      |=> s_ff.rdata == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved word nonzero"); // see R12

  property p_no_err;
    (s_ff.st == ST_XFER && !PACKET) |-> !s_ff.errst;
  endproperty
  a_no_err: assert property (p_no_err) else $error("identify reported error"); // see R18

  property p_dword;
    (req.rd && req.addr == A_DATA && s_ff.st == ST_XFER && s_ff.idx == 8'(W_TOTAL + 1))
      |=> s_ff.rdata == u_rom.TOTAL[31:16];
  endproperty
  a_dword: assert property (p_dword) else $error("high half order wrong"); // see R14

  // status command reporting: clean finish, one check per media bit, and the fault bit
  property p_gms_clean;
    (s_ff.st == ST_EXEC && merr == 8'h00) |=> stat == 8'h40;
  endproperty
  a_gms_clean: assert property (p_gms_clean) else $error("clean status not plain"); // see R1

  property p_gms_wp;
    (s_ff.st == ST_EXEC && med.msn && med.media && med.wp) |=> s_ff.err[EB_WP] && s_ff.errst;
  endproperty
  a_gms_wp: assert property (p_gms_wp) else $error("write protect not reported"); // see R6

  property p_gms_mc;
    (s_ff.st == ST_EXEC && med.msn && med.mc) |=> s_ff.err[EB_MC];
  endproperty
  a_gms_mc: assert property (p_gms_mc) else $error("media change not reported"); // see R5

  property p_gms_mcr;
    (s_ff.st == ST_EXEC && med.msn && med.mcr) |=> s_ff.err[EB_MCR];
  endproperty
  a_gms_mcr: assert property (p_gms_mcr) else $error("eject request not reported"); // see R4

  property p_nm_gone;
    (s_ff.st == ST_EXEC && med.media) |=> !s_ff.err[EB_NM];
  endproperty
  a_nm_gone: assert property (p_nm_gone) else $error("no media with media present"); // see R3

  property p_df_fault;
    (s_ff.st == ST_EXEC && !med.fault) |=> !s_ff.df;
  endproperty
  a_df_fault: assert property (p_df_fault) else $error("fault shown without fault"); // see R7

  // identify hand-over
  property p_irq_set;
    (s_ff.st == ST_PREP && s_ff.cnt == 8'h00 && !med.nien) |=> s_ff.intrq;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("identify interrupt lost"); // see R10

  property p_irq_mask;
    (s_ff.st == ST_PREP && s_ff.cnt == 8'h00 && med.nien) |=> !s_ff.intrq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised"); // see R10

  property p_pkt_abort;
    (cmd_take && req.wdata == CMD_IDENT && PACKET)
      |=> s_ff.err[EB_ABRT] && s_ff.errst && s_ff.cblk == SIG && s_ff.st == ST_IDLE;
  endproperty
  a_pkt_abort: assert property (p_pkt_abort) else $error("packet identify not aborted"); // see R17

  property p_xfer_end;
    (req.rd && req.addr == A_DATA && s_ff.st == ST_XFER && s_ff.idx == ID_LAST)
      |=> s_ff.st == ST_IDLE && stat == 8'h40;
  endproperty
  a_xfer_end: assert property (p_xfer_end) else $error("identify end not clean"); // see R9

  property p_word_step;
    (req.rd && req.addr == A_DATA && s_ff.st == ST_XFER)
      |=> s_ff.rdata == $past(id_word) && s_ff.idx == $past(s_ff.idx) + 8'h01;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word not handed in order"); // see R13

  property p_ascii;
    (req.rd && req.addr == A_DATA && s_ff.st == ST_XFER && s_ff.idx >= 8'(W_FW)
     && s_ff.idx < 8'(W_MODEL + N_MODEL))
      |=> s_ff.rdata[15:8] inside {[ASCII_LO:ASCII_HI]}
          && s_ff.rdata[7:0] inside {[ASCII_LO:ASCII_HI]};
  endproperty
  a_ascii: assert property (p_ascii) else $error("string byte not graphic"); // see R15
endmodule

//--- verif/msi_host_model.sv
// Purpose: host adapter model issuing task-file reads and writes
// Assumes: one-cycle strobes; read answer stands one edge after the take edge
// Notes:   idle address and data are inverted so stale values never look valid
`timescale 1ns/1ps
module msi_host_model (
  // clock
  input  wire logic         clk,
  // task-file side
  output msi_pkg::msi_req_s req,
  input  wire logic [15:0]  rdata
);
  import msi_pkg::*;

  // bus idle from time zero
  initial req = '0;

  // one write strobe; an extra edge keeps back-to-back strobes apart
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    req.wr    = 1'b0;
    req.addr  = ~a;
    req.wdata = ~d;
    @(posedge clk);
    #1;
  endtask

  // identification words are fetched one data-register read at a time
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    req.rd   = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    req.rd   = 1'b0;
    req.addr = ~a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule

//--- verif/tb_msi_cmd_top.sv
// Purpose: self-checking bench for the media status and identify engine
// Assumes: rom defaults for geometry and strings, short prep count
// Notes:   interrupt waits are bounded; pins settle through the synchroniser
`timescale 1ns/1ps
module tb_msi_cmd_top;
  import msi_pkg::*;
  localparam int          PRP = 4;
  localparam logic [31:0] TOT = 32'h000fc000;
  localparam logic [31:0] SGP = 32'h5a3c_96e1; // arbitrary signature for the packet twin
  logic        clk;
  logic        rst_n;
  logic        intrq;
  logic        intrq_p;
  logic [15:0] rdata_p;
  logic [5:0]  pins;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [15:0] idw [256];
  msi_req_s    req;
  int          failures;
  int          comparisons;
  int          k;

  msi_cmd_top #(.PREP(PRP)) i_msi_cmd_top (.clk(clk), .rst_n(rst_n), .req(req),
    .rdata(rdata), .intrq(intrq), .pins(pins));
  // packet-feature twin on the same bus; only its identify answer differs
  msi_cmd_top #(.PACKET(1'b1), .PREP(PRP), .SIG(SGP)) i_msi_cmd_top_pkt (.clk(clk),
    .rst_n(rst_n), .req(req), .rdata(rdata_p), .intrq(intrq_p), .pins(pins));
  msi_host_model i_msi_host_model (.clk(clk), .req(req), .rdata(rdata));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one comparison, counted
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rchk(input string n, input logic [2:0] a, input logic [15:0] e);
    logic [15:0] v;
    i_msi_host_model.rd(a, v);
    chk(n, e, v);
  endtask

  // long enough for the three-flop synchroniser
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // status command, completion seen through the interrupt
  task automatic gms(input logic [7:0] ee, input logic [7:0] se);
    i_msi_host_model.wr(A_STAT, CMD_GMS);
    for (k = 0; k < 50 && intrq !== 1'b1; k++) @(posedge clk);
    #1;
    chk("intrq", 16'h0001, {15'h0, intrq});
    rchk("error_flags", A_ERR, {8'h00, ee});
    rchk("command_state", A_STAT, {8'h00, se});
  endtask

  // hang guard well beyond the expected run
  initial begin
    #500000;
    failures++;
    close_out();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    pins = 6'h00;
    failures = 0;
    comparisons = 0;
    #1;
    chk("rdata in reset", 16'h0000, rdata);
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rchk("idle state", A_STAT, 16'h0040);
    rchk("device_select reset", A_DEVH, {8'h00, DEVH_RST});
    i_msi_host_model.wr(A_DEVH, 8'h0f);
    rchk("device_select rw", A_DEVH, 16'h000f);
    i_msi_host_model.wr(A_DEVH, 8'h00);
    i_msi_host_model.wr(A_ERR, 8'hff);
    rchk("error_flags ro", A_ERR, {8'h00, ERR_RST});
    gms(8'h00, 8'h40);
    pins[P_MSN] = 1'b1;
    settle();
    gms(8'h02, 8'h41);
    gms(8'h02, 8'h41);
    pins = 6'h17;
    settle();
    pins[P_EJECT] = 1'b0;
    settle();
    gms(8'h68, 8'h41);
    pins[P_FAULT] = 1'b1;
    settle();
    gms(8'h40, 8'h61);
    pins[P_MSN] = 1'b0;
    settle();
    gms(8'h00, 8'h40);
    pins[P_FAULT] = 1'b0;
    i_msi_host_model.wr(A_STAT, 8'h00);
    rchk("abort error", A_ERR, 16'h0004);
    rchk("abort state", A_STAT, 16'h0041);
    // identify with interrupts masked
    pins[P_NIEN] = 1'b1;
    settle();
    i_msi_host_model.wr(A_STAT, CMD_IDENT);
    i_msi_host_model.rd(A_STAT, d);
    chk("busy", 16'h0080, d & 16'h0080);
    for (k = 0; k < 50 && d[SB_DRQ] !== 1'b1; k++) i_msi_host_model.rd(A_STAT, d);
    chk("data ready", 16'h0048, d);
    chk("masked intrq", 16'h0000, {15'h0, intrq});
    for (int j = 0; j < 256; j++) i_msi_host_model.rd(A_DATA, idw[j]);
    rchk("identify done", A_STAT, 16'h0040);
    chk("config", 16'h0080, idw[W_CONFIG] & 16'h0081);
    chk("cylinders", 16'h0400, idw[W_CYL]);
    chk("heads", 16'h0010, idw[W_HEAD]);
    chk("sectors", 16'h003f, idw[W_SECT]);
    chk("total low", TOT[15:0], idw[W_TOTAL]);
    chk("total high", TOT[31:16], idw[W_TOTAL+1]);
    chk("serial", 16'h534e, idw[W_SER]);
    chk("firmware first", 16'h5245, idw[W_FW]);
    chk("firmware last", 16'h3030, idw[W_FW+3]);
    chk("reserved 2", 16'h0000, idw[2]);
    chk("reserved 48", 16'h0000, idw[48]);
    chk("reserved 255", 16'h0000, idw[255]);
    // every string byte stays printable; words 20 to 22 between serial and firmware are skipped
    for (int j = W_SER; j < W_MODEL + N_MODEL; j++) begin
      if (j < W_SER + N_SER || j >= W_FW) begin
        d = idw[j];
        chk("ascii", 16'h0001, {15'h0, d[15:8] >= ASCII_LO && d[15:8] <= ASCII_HI &&
          d[7:0] >= ASCII_LO && d[7:0] <= ASCII_HI});
      end
    end
    // packet twin: aborted identify left its signature in the command block
    for (int j = 0; j < 4; j++) begin
      i_msi_host_model.rd(3'(A_SCNT + j), d);
      chk("packet signature", {8'h00, SGP[8*j +: 8]}, rdata_p);
    end
    i_msi_host_model.rd(A_ERR, d);
    chk("packet abort", 16'h0004, rdata_p);
    i_msi_host_model.rd(A_STAT, d);
    chk("packet state", 16'h0041, rdata_p);
    // identify with interrupts enabled; second poll meets the raising edge
    pins[P_NIEN] = 1'b0;
    settle();
    i_msi_host_model.wr(A_STAT, CMD_IDENT);
    chk("packet intrq", 16'h0001, {15'h0, intrq_p});
    repeat (2) i_msi_host_model.rd(A_STAT, d);
    for (k = 0; k < 50 && intrq !== 1'b1; k++) @(posedge clk);
    #1;
    chk("identify intrq", 16'h0001, {15'h0, intrq});
    rchk("identify drq", A_STAT, 16'h0048);
    for (int j = 0; j < 256; j++) begin
      i_msi_host_model.rd(A_DATA, d);
      if (j == W_TOTAL) chk("total low again", TOT[15:0], d);
    end
    rchk("identify done again", A_STAT, 16'h0040);
    close_out();
  end
endmodule
